// ---- design/link_bridge_pkg.sv ----
// Constants, types and decode functions shared by the link bridge files
package link_bridge_pkg;

  // Command codes
  localparam logic [5:0] CMD_NOP = 6'h00;
  localparam logic [5:0] CMD_FLUSH = 6'h01;
  localparam logic [5:0] CMD_RD_RESP = 6'h30;
  localparam logic [5:0] CMD_TGT_DONE = 6'h33;
  localparam logic [5:0] CMD_COH_WR = 6'h34;
  localparam logic [5:0] CMD_WR_ADDR_EXT = 6'h35;
  localparam logic [5:0] CMD_COH_RESP = 6'h38;
  localparam logic [5:0] CMD_COH_RD = 6'h39;
  localparam logic [5:0] CMD_BCAST = 6'h3a;
  localparam logic [5:0] CMD_RD_ADDR_EXT = 6'h3b;
  localparam logic [5:0] CMD_FENCE = 6'h3c;
  localparam logic [5:0] CMD_SYNC = 6'h3f;

  // Command field positions
  localparam int CMD_POSTED_BIT = 5;
  localparam int CMD_DWORD_BIT = 2;
  localparam int CMD_EXT_BIT = 0;

  // Sizes
  localparam int NUM_VECTORS = 256;
  localparam int NUM_RX_WIN = 3;
  localparam int NUM_POST_WIN = 2;
  localparam int NUM_PREF_WIN = 2;
  localparam int NUM_UNC_WIN = 2;

  // System map: four 1 TB link windows from this base, selected by bits 41:40
  localparam logic [47:0] LINK_WIN_BASE = 48'h0c00_0000_0000;

  // Link address map
  localparam logic [39:0] MEM_END = 40'h00fc_ffff_ffff;
  localparam logic [39:0] INTR_BASE = 40'h00fd_f800_0000;
  localparam logic [39:0] PIC_BASE = 40'h00fd_f900_0000;
  localparam logic [39:0] SYSMSG_BASE = 40'h00fd_f910_0000;
  localparam logic [39:0] CTRL_CFG_BASE = 40'h00fd_fb00_0000;
  localparam logic [39:0] IO_BASE = 40'h00fd_fc00_0000;
  localparam logic [39:0] BUS_CFG_BASE = 40'h00fd_fe00_0000;

  // Cycles after reset release before the strap is taken
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    REG_MEM, REG_INTR, REG_PIC, REG_SYSMSG, REG_CTRL_CFG, REG_IO, REG_BUS_CFG, REG_RSVD
  } region_t;

  typedef enum logic [1:0] {
    link0_lower_port, link0_upper_port, link1_lower_port, link1_upper_port
  } port_t;

  typedef struct packed {
    logic en;
    logic [39:0] base;
    logic [39:0] mask;
  } win_t;

  typedef struct packed {
    logic [5:0] cmd;
    logic [39:0] addr;
    logic [7:0] data;
    logic err;
  } link_pkt_t;

  typedef struct packed {
    logic write;
    logic spec;
    logic dword;
    logic [47:0] addr;
  } int_req_t;

  typedef struct packed {
    link_pkt_t pkt;
    region_t region;
    logic uncache;
  } svc_t;

  // Link space decode
  function automatic region_t region_of(input logic [39:0] a);
    region_t r;
    r = REG_RSVD;
    if (a <= MEM_END) r = REG_MEM;
    else if (a[39:24] == INTR_BASE[39:24]) r = REG_INTR;
    else if (a[39:20] == PIC_BASE[39:20]) r = REG_PIC;
    else if (a[39:20] == SYSMSG_BASE[39:20]) r = REG_SYSMSG;
    else if (a[39:24] == CTRL_CFG_BASE[39:24]) r = REG_CTRL_CFG;
    else if (a[39:25] == IO_BASE[39:25]) r = REG_IO;
    else if (a[39:25] == BUS_CFG_BASE[39:25]) r = REG_BUS_CFG;
    return r;
  endfunction : region_of

  // Write commands, extension write commands included
  function automatic logic is_write(input logic [5:0] c);
    return (c[4:3] == 2'b01) || (c == CMD_COH_WR) || (c == CMD_WR_ADDR_EXT);
  endfunction : is_write

  // Read commands, extension read commands included
  function automatic logic is_read(input logic [5:0] c);
    return (c[5:4] == 2'b01) || (c == CMD_COH_RD) || (c == CMD_RD_ADDR_EXT);
  endfunction : is_read

  // Outgoing write, pattern x01x0x
  function automatic logic [5:0] enc_write(input logic posted, input logic dw,
                                           input logic ext);
    return {posted | ext, 2'b01, dw, 1'b0, ext};
  endfunction : enc_write

  // Outgoing read, pattern 010x0x
  function automatic logic [5:0] enc_read(input logic dw, input logic ext);
    return {3'b010, dw, 1'b0, ext};
  endfunction : enc_read

endpackage : link_bridge_pkg

// ---- design/addr_window_match.sv ----
// Hit detection against a set of base and mask address windows
`timescale 1ns/100ps
`default_nettype none

module addr_window_match
  import link_bridge_pkg::*;
#(
  parameter int N = 2
) (
  // Window set
  input wire win_t [N-1:0] win_in,
  // Address under test
  input wire logic [39:0] addr_in,
  output logic hit_out
);

  always_comb begin
    hit_out = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (win_in[i].en && ((addr_in & win_in[i].mask) == win_in[i].base)) begin
        hit_out = 1'b1;
      end
    end
  end

endmodule : addr_window_match

`default_nettype wire

// ---- design/intr_vector_store.sv ----
// Sticky store of the 256 interrupt vectors with masked notification
`timescale 1ns/100ps
`default_nettype none

module intr_vector_store
  import link_bridge_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Set and clear
  input wire logic set_in,
  input wire logic [7:0] set_idx_in,
  input wire logic [NUM_VECTORS-1:0] clear_in,
  input wire logic [NUM_VECTORS-1:0] mask_in,
  // State
  output logic [NUM_VECTORS-1:0] vec_out,
  output logic notify_out
);

  logic [NUM_VECTORS-1:0] vec_reg;
  logic [NUM_VECTORS-1:0] vec_next;
  logic notify_reg;
  logic notify_next;

  // Set wins over a clear in the same cycle; notify only where unmasked
  always_comb begin
    vec_next = vec_reg & ~clear_in;
    if (set_in) begin
      vec_next[set_idx_in] = 1'b1;
    end
    notify_next = |(vec_next & mask_in);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vec_reg <= '0;
      notify_reg <= 1'b0;
    end else begin
      vec_reg <= vec_next;
      notify_reg <= notify_next;
    end
  end

  assign vec_out = vec_reg;
  assign notify_out = notify_reg;

endmodule : intr_vector_store

`default_nettype wire

// ---- design/link_cmd_decode_addr_windows.sv ----
// Link command decode and encode, interrupt capture and window routing
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Code 000000 is empty or flow control; flush 000001 does nothing.
// - Standard write: bit 5 picks nonposted or posted; bit 2 byte or doubleword.
// - Extension mode writes carry bits 5 and 0 set; reads carry bit 0 set.
// - 110000 returns read data; 110011 completes a nonposted write.
// - Extension mode handles coherent and address extension commands.
// - Broadcast does nothing; fence orders earlier before later requests.
// - Sent writes x01x0x, reads 010x0x; bit 0 follows mode; sync never originated.
// - 256 interrupt vectors; fixed and arbitrated messages are accepted.
// - No end-of-interrupt message is ever generated by hardware.
// - Interrupt message sets its vector bit; notify only where unmasked.
// - PIC request, vector query and return done in hardware; vector recorded.
// - Four 1 TB link windows from 0x0C00_0000_0000 upward.
// - Each link decodes a 40-bit space from the low system address bits.
// - Link addresses up to 0xFC_FFFF_FFFF are memory space.
// - Interrupt, PIC response and system message regions are decoded.
// - Controller config, I/O and link config regions; gaps reserved.
// - Host role: window hits served inside, misses sent back peer-to-peer.
// - Slave role: window misses get an error response.
// - Writes in post windows go posted; completion given once sent.
// - Speculative reads answered locally unless a prefetch window is hit.
// - DMA in uncache windows bypasses coherence; others stay coherent.
// - Slave role bit resets to 0, then takes the inverse of the host role strap.
module link_cmd_decode_addr_windows
  import link_bridge_pkg::*;
#(
  parameter port_t OWN_PORT = link0_lower_port
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // Mode and strap
  input wire logic ext_mode_in,
  input wire logic host_role_strap_in,
  output logic slave_role_select_out,
  // Receive link pins
  input wire logic link_clk_in,
  input wire logic rx_valid_in,
  input wire link_pkt_t rx_pkt_in,
  // Transmit link
  output logic tx_valid_out,
  output var link_pkt_t tx_pkt_out,
  output var port_t tx_port_out,
  // Window configuration
  input wire win_t [NUM_RX_WIN-1:0] rx_win_in,
  input wire win_t [NUM_POST_WIN-1:0] post_win_in,
  input wire win_t [NUM_PREF_WIN-1:0] pref_win_in,
  input wire win_t [NUM_UNC_WIN-1:0] unc_win_in,
  // Internal requests
  input wire logic int_req_valid_in,
  input wire int_req_t int_req_in,
  output logic int_req_ready_out,
  output logic int_done_out,
  output logic int_done_err_out,
  // Inbound service
  output logic svc_valid_out,
  output var svc_t svc_out,
  output logic fence_out,
  output logic rx_bad_out,
  // Interrupts
  input wire logic [NUM_VECTORS-1:0] intr_mask_in,
  input wire logic [NUM_VECTORS-1:0] intr_clear_in,
  input wire logic pic_clear_in,
  output logic [NUM_VECTORS-1:0] intr_vec_out,
  output logic intr_notify_out,
  output logic pic_busy_out
);

  typedef enum logic [1:0] {PIC_IDLE, PIC_QUERY, PIC_CLEAR} pic_state_t;

  // Synchronisers for pins
  logic lclk_s1, lclk_s2, lclk_s3;
  logic rxv_s1, rxv_s2;
  link_pkt_t rx_s1, rx_s2;
  logic strap_s1, strap_s2;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lclk_s1 <= 1'b0;
      lclk_s2 <= 1'b0;
      lclk_s3 <= 1'b0;
      rxv_s1 <= 1'b0;
      rxv_s2 <= 1'b0;
      rx_s1 <= '0;
      rx_s2 <= '0;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
    end else begin
      lclk_s1 <= link_clk_in;
      lclk_s2 <= lclk_s1;
      lclk_s3 <= lclk_s2;
      rxv_s1 <= rx_valid_in;
      rxv_s2 <= rxv_s1;
      rx_s1 <= rx_pkt_in;
      rx_s2 <= rx_s1;
      strap_s1 <= host_role_strap_in;
      strap_s2 <= strap_s1;
    end
  end

  logic rx_fire;
  assign rx_fire = lclk_s2 && !lclk_s3 && rxv_s2;

  // Window hits
  logic rx_hit, unc_hit, post_hit, pref_hit;

  addr_window_match #(.N(NUM_RX_WIN)) u_rx_win (
    .win_in(rx_win_in),
    .addr_in(rx_s2.addr),
    .hit_out(rx_hit)
  );
  addr_window_match #(.N(NUM_UNC_WIN)) u_unc_win (
    .win_in(unc_win_in),
    .addr_in(rx_s2.addr),
    .hit_out(unc_hit)
  );
  addr_window_match #(.N(NUM_POST_WIN)) u_post_win (
    .win_in(post_win_in),
    .addr_in(int_req_in.addr[39:0]),
    .hit_out(post_hit)
  );
  addr_window_match #(.N(NUM_PREF_WIN)) u_pref_win (
    .win_in(pref_win_in),
    .addr_in(int_req_in.addr[39:0]),
    .hit_out(pref_hit)
  );

  // State
  logic [1:0] settle_reg, settle_next;
  logic slave_reg, slave_next;
  pic_state_t pic_reg, pic_next;
  logic pend_reg, pend_next;
  link_pkt_t pend_pkt_reg, pend_pkt_next;
  logic tx_valid_reg, tx_valid_next;
  link_pkt_t tx_pkt_reg, tx_pkt_next;
  port_t tx_port_reg, tx_port_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic done_err_reg, done_err_next;
  logic svc_valid_reg, svc_valid_next;
  svc_t svc_reg, svc_next;
  logic fence_reg, fence_next;
  logic bad_reg, bad_next;
  logic pic_busy_reg, pic_busy_next;
  logic set_v;
  logic [7:0] set_idx;
  logic int_take;
  logic in_link_win;
  logic ext_bad;
  logic posted;
  region_t rx_region;

  always_comb begin
    settle_next = settle_reg;
    slave_next = slave_reg;
    pic_next = pic_reg;
    pend_next = 1'b0;
    pend_pkt_next = pend_pkt_reg;
    tx_valid_next = 1'b0;
    tx_pkt_next = tx_pkt_reg;
    tx_port_next = tx_port_reg;
    done_next = 1'b0;
    done_err_next = 1'b0;
    svc_valid_next = 1'b0;
    svc_next = svc_reg;
    fence_next = 1'b0;
    bad_next = 1'b0;
    set_v = 1'b0;
    set_idx = rx_s2.data;
    rx_region = region_of(rx_s2.addr);
    ext_bad = ext_mode_in && (((rx_s2.cmd[4:3] == 2'b01)
      && !(rx_s2.cmd[CMD_POSTED_BIT] && rx_s2.cmd[CMD_EXT_BIT]))
      || ((rx_s2.cmd[5:4] == 2'b01) && !rx_s2.cmd[CMD_EXT_BIT]));
    in_link_win = int_req_in.addr[47:42] == LINK_WIN_BASE[47:42];
    int_take = int_req_valid_in && ready_reg;
    posted = ext_mode_in || post_hit;
    // Strap taken once the synchroniser holds it
    if (settle_reg != STRAP_SETTLE) begin
      settle_next = settle_reg + 2'h1;
      if (settle_reg == STRAP_SETTLE - 2'h1) begin
        slave_next = !strap_s2;
      end
    end
    // Software clears the PIC before a new PIC interrupt is taken
    if ((pic_reg == PIC_CLEAR) && pic_clear_in) begin
      pic_next = PIC_IDLE;
    end
    // Pending link answer goes out first
    if (pend_reg) begin
      tx_valid_next = 1'b1;
      tx_pkt_next = pend_pkt_reg;
      tx_port_next = OWN_PORT;
    end
    // Received packets
    if (rx_fire) begin
      if (is_write(rx_s2.cmd) && rx_region == REG_INTR) begin
        set_v = 1'b1;
      end else if (is_write(rx_s2.cmd) && rx_region == REG_SYSMSG) begin
        if (pic_reg == PIC_IDLE) begin
          pend_next = 1'b1;
          pend_pkt_next = '{cmd: enc_read(1'b0, ext_mode_in), addr: PIC_BASE,
                            data: 8'h00, err: 1'b0};
          pic_next = PIC_QUERY;
        end
      end else if ((rx_s2.cmd == CMD_RD_RESP || rx_s2.cmd == CMD_COH_RESP)
                   && pic_reg == PIC_QUERY) begin
        set_v = 1'b1;
        pic_next = PIC_CLEAR;
      end else if (rx_s2.cmd == CMD_TGT_DONE) begin
        done_next = 1'b1;
        done_err_next = rx_s2.err;
      end else if (rx_s2.cmd == CMD_RD_RESP || rx_s2.cmd == CMD_COH_RESP) begin
        svc_valid_next = 1'b1;
        svc_next = '{pkt: rx_s2, region: rx_region, uncache: 1'b0};
      end else if (rx_s2.cmd == CMD_FENCE) begin
        fence_next = 1'b1;
      end else if (is_write(rx_s2.cmd) || is_read(rx_s2.cmd)) begin
        if (ext_bad) begin
          bad_next = 1'b1;
        end else if (rx_hit) begin
          svc_valid_next = 1'b1;
          svc_next = '{pkt: rx_s2, region: rx_region, uncache: unc_hit};
        end else if (!slave_reg) begin
          pend_next = 1'b1;
          pend_pkt_next = rx_s2;
        end else begin
          pend_next = 1'b1;
          pend_pkt_next = '{cmd: is_read(rx_s2.cmd) ? CMD_RD_RESP : CMD_TGT_DONE,
                            addr: rx_s2.addr, data: 8'h00, err: 1'b1};
        end
      end
      // Nop, flush, broadcast, sync and unsupported codes have no effect
    end
    // Internal requests toward the link
    if (int_take) begin
      if (!in_link_win) begin
        done_next = 1'b1;
        done_err_next = 1'b1;
      end else if (!int_req_in.write && int_req_in.spec && !pref_hit) begin
        done_next = 1'b1;
      end else begin
        tx_valid_next = 1'b1;
        tx_port_next = port_t'(int_req_in.addr[41:40]);
        tx_pkt_next.addr = int_req_in.addr[39:0];
        tx_pkt_next.data = 8'h00;
        tx_pkt_next.err = 1'b0;
        if (int_req_in.write) begin
          tx_pkt_next.cmd = enc_write(posted, int_req_in.dword, ext_mode_in);
          done_next = posted;
        end else begin
          tx_pkt_next.cmd = enc_read(int_req_in.dword, ext_mode_in);
        end
      end
    end
    ready_next = !pend_next;
    pic_busy_next = pic_next != PIC_IDLE;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      settle_reg <= 2'h0;
      slave_reg <= 1'b0;
      pic_reg <= PIC_IDLE;
      pend_reg <= 1'b0;
      pend_pkt_reg <= '0;
      tx_valid_reg <= 1'b0;
      tx_pkt_reg <= '0;
      tx_port_reg <= link0_lower_port;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      done_err_reg <= 1'b0;
      svc_valid_reg <= 1'b0;
      svc_reg <= '0;
      fence_reg <= 1'b0;
      bad_reg <= 1'b0;
      pic_busy_reg <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      slave_reg <= slave_next;
      pic_reg <= pic_next;
      pend_reg <= pend_next;
      pend_pkt_reg <= pend_pkt_next;
      tx_valid_reg <= tx_valid_next;
      tx_pkt_reg <= tx_pkt_next;
      tx_port_reg <= tx_port_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      done_err_reg <= done_err_next;
      svc_valid_reg <= svc_valid_next;
      svc_reg <= svc_next;
      fence_reg <= fence_next;
      bad_reg <= bad_next;
      pic_busy_reg <= pic_busy_next;
    end
  end

  intr_vector_store u_vec (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .set_in(set_v),
    .set_idx_in(set_idx),
    .clear_in(intr_clear_in),
    .mask_in(intr_mask_in),
    .vec_out(intr_vec_out),
    .notify_out(intr_notify_out)
  );

  assign slave_role_select_out = slave_reg;
  assign tx_valid_out = tx_valid_reg;
  assign tx_pkt_out = tx_pkt_reg;
  assign tx_port_out = tx_port_reg;
  assign int_req_ready_out = ready_reg;
  assign int_done_out = done_reg;
  assign int_done_err_out = done_err_reg;
  assign svc_valid_out = svc_valid_reg;
  assign svc_out = svc_reg;
  assign fence_out = fence_reg;
  assign rx_bad_out = bad_reg;
  assign pic_busy_out = pic_busy_reg;

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_nop_no_effect: assert property (
    rx_fire && (rx_s2.cmd == CMD_NOP || rx_s2.cmd == CMD_FLUSH || rx_s2.cmd == CMD_BCAST)
    |=> !svc_valid_reg && !pend_reg && !fence_reg && !done_reg)
    else $error("no-op command had an effect");

  a_ext_tx_bits: assert property (
    int_take && in_link_win && int_req_in.write && ext_mode_in
    |=> tx_valid_reg && tx_pkt_reg.cmd[CMD_POSTED_BIT] && tx_pkt_reg.cmd[CMD_EXT_BIT] && done_reg)
    else $error("extension write not posted with bit 0 set");

  a_tx_read_pattern: assert property (
    int_take && in_link_win && !int_req_in.write && !int_req_in.spec
    |=> tx_valid_reg && tx_pkt_reg.cmd[5:3] == 3'b010 && !tx_pkt_reg.cmd[1]
        && tx_pkt_reg.cmd[CMD_EXT_BIT] == $past(ext_mode_in))
    else $error("read command pattern wrong");

  a_no_sync_origin: assert property (
    tx_valid_reg |-> tx_pkt_reg.cmd != CMD_SYNC)
    else $error("sync packet originated");

  a_intr_capture: assert property (
    rx_fire && is_write(rx_s2.cmd) && rx_region == REG_INTR
    |=> ##1 intr_vec_out[$past(rx_s2.data, 2)])
    else $error("interrupt vector bit not set");

  a_pic_query: assert property (
    rx_fire && is_write(rx_s2.cmd) && rx_region == REG_SYSMSG && pic_reg == PIC_IDLE
    |=> pend_reg ##1 tx_valid_reg && tx_pkt_reg.addr == PIC_BASE && pic_busy_reg)
    else $error("PIC vector query not sent");

  a_host_miss_fwd: assert property (
    rx_fire && is_read(rx_s2.cmd) && !ext_bad && !rx_hit && !slave_reg
    |=> pend_reg && !pend_pkt_reg.err ##1 tx_valid_reg && tx_port_reg == OWN_PORT)
    else $error("host miss not forwarded");

  a_slave_miss_err: assert property (
    rx_fire && is_read(rx_s2.cmd) && !ext_bad && !rx_hit && slave_reg
    |=> pend_reg && pend_pkt_reg.err && pend_pkt_reg.cmd == CMD_RD_RESP)
    else $error("slave miss not answered with error");

  a_post_done: assert property (
    int_take && in_link_win && int_req_in.write && post_hit
    |=> tx_valid_reg && done_reg && tx_pkt_reg.cmd[CMD_POSTED_BIT])
    else $error("posted write completion missing");

  a_spec_local: assert property (
    int_take && in_link_win && !int_req_in.write && int_req_in.spec && !pref_hit
    |=> done_reg && !tx_valid_reg)
    else $error("speculative read reached the link");

  a_strap_take: assert property (
    settle_reg == STRAP_SETTLE - 2'h1 |=> slave_reg == !$past(strap_s2))
    else $error("slave role not taken from strap");

endmodule : link_cmd_decode_addr_windows

`default_nettype wire

// ---- test/link_peer_model.sv ----
// Peer link device model driving the receive side of the link
`timescale 1ns/100ps
`default_nettype none
module link_peer_model
  import link_bridge_pkg::*;
(
  // Link towards the block
  output logic link_clk_out,
  output logic valid_out,
  output var link_pkt_t pkt_out
);
  initial begin
    link_clk_out = 1'b0;
    valid_out = 1'b0;
    pkt_out = '0;
  end
  // One packet per frame, never an atomic command; clock still between frames
  task automatic send(input logic [5:0] c, input logic [39:0] a, input logic [7:0] d);
    valid_out = 1'b1;
    pkt_out = '{cmd: c, addr: a, data: d, err: 1'b0};
    #24 link_clk_out = 1'b1;
    #24 link_clk_out = 1'b0;
    valid_out = 1'b0;
    pkt_out = ~pkt_out;
    #96;
  endtask : send
endmodule : link_peer_model
`default_nettype wire

// ---- test/link_cmd_decode_addr_windows_test.sv ----
// Self-checking bench for the link command decode and window routing block
`timescale 1ns/100ps
`default_nettype none
module link_cmd_decode_addr_windows_test;
  import link_bridge_pkg::*;
  logic sys_clk_in, rstn_in, ext_mode_in, strap, rx_valid, link_clk, int_req_valid_in;
  logic pic_clear_in, slave_role_select_out, tx_valid_out, int_req_ready_out, int_done_out;
  logic svc_valid_out, fence_out, rx_bad_out, intr_notify_out, pic_busy_out, int_done_err_out;
  link_pkt_t rx_pkt, tx_pkt_out, last_tx;
  port_t tx_port_out, last_port;
  win_t [NUM_RX_WIN-1:0] rx_win;
  win_t [NUM_POST_WIN-1:0] post_win;
  win_t [NUM_PREF_WIN-1:0] pref_win;
  win_t [NUM_UNC_WIN-1:0] unc_win;
  int_req_t int_req_in;
  svc_t svc_out, last_svc;
  logic [NUM_VECTORS-1:0] mask, clr, intr_vec_out;
  int n_errors, num_checks, n_tx, n_svc, n_done, n_fence, n_bad, n_derr;

  link_cmd_decode_addr_windows i_link_cmd_decode_addr_windows (
    .sys_clk_in, .rstn_in, .ext_mode_in, .host_role_strap_in(strap),
    .slave_role_select_out, .link_clk_in(link_clk), .rx_valid_in(rx_valid),
    .rx_pkt_in(rx_pkt), .tx_valid_out, .tx_pkt_out, .tx_port_out,
    .rx_win_in(rx_win), .post_win_in(post_win), .pref_win_in(pref_win),
    .unc_win_in(unc_win), .int_req_valid_in, .int_req_in, .int_req_ready_out,
    .int_done_out, .int_done_err_out, .svc_valid_out, .svc_out, .fence_out,
    .rx_bad_out, .intr_mask_in(mask), .intr_clear_in(clr), .pic_clear_in,
    .intr_vec_out, .intr_notify_out, .pic_busy_out);
  link_peer_model i_link_peer_model (.link_clk_out(link_clk), .valid_out(rx_valid),
    .pkt_out(rx_pkt));

  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // Count output pulses and keep the last payloads
  always @(negedge sys_clk_in) begin
    if (tx_valid_out === 1'b1) begin
      n_tx++;
      last_tx = tx_pkt_out;
      last_port = tx_port_out;
    end
    if (svc_valid_out === 1'b1) begin
      n_svc++;
      last_svc = svc_out;
    end
    n_done += (int_done_out === 1'b1);
    n_derr += (int_done_out === 1'b1 && int_done_err_out === 1'b1);
    n_fence += (fence_out === 1'b1);
    n_bad += (rx_bad_out === 1'b1);
  end

  task automatic chk(input string what, input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic clr_cnt;
    n_tx = 0; n_svc = 0; n_done = 0; n_fence = 0; n_bad = 0; n_derr = 0;
  endtask : clr_cnt

  task automatic do_reset(input logic s);
    strap = s;
    rstn_in = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1 chk("ready in reset", int_req_ready_out, 1'b0);
    rstn_in = 1'b1;
    repeat (8) @(posedge sys_clk_in);
    #1 chk("slave role", slave_role_select_out, !s);
    $display("test reset done");
  endtask : do_reset

  task automatic int_req(input logic w, input logic sp, input logic dw, input logic [47:0] a);
    clr_cnt();
    int_req_in = '{write: w, spec: sp, dword: dw, addr: a};
    int_req_valid_in = 1'b1;
    do @(negedge sys_clk_in); while (int_req_ready_out !== 1'b1);
    @(posedge sys_clk_in);
    #1 int_req_valid_in = 1'b0;
    repeat (10) @(posedge sys_clk_in);
    #1;
  endtask : int_req

  task automatic rx(input logic [5:0] c, input logic [39:0] a, input logic [7:0] d);
    clr_cnt();
    i_link_peer_model.send(c, a, d);
    repeat (6) @(posedge sys_clk_in);
    #1;
  endtask : rx

  task automatic test_internal;
    int_req(1'b1, 1'b0, 1'b1, 48'h0d01_0000_0040);
    chk("posted wr cmd", last_tx.cmd, 6'h2c);
    chk("posted wr addr", last_tx.addr, 40'h01_0000_0040);
    chk("posted wr port", last_port, link0_upper_port);
    chk("posted wr done", n_done, 1);
    int_req(1'b0, 1'b1, 1'b0, 48'h0c00_0000_0100);
    chk("spec rd tx", n_tx, 0);
    chk("spec rd done", n_done, 1);
    int_req(1'b0, 1'b0, 1'b1, 48'h0e00_0000_0300);
    chk("rd cmd", last_tx.cmd, 6'h14);
    chk("rd port", last_port, link1_lower_port);
    int_req(1'b1, 1'b0, 1'b0, 48'h0c00_0000_0400);
    chk("nonposted wr cmd", last_tx.cmd, 6'h08);
    chk("nonposted wr done", n_done, 0);
    int_req(1'b1, 1'b0, 1'b0, 48'h0000_0000_0080);
    chk("outside tx", n_tx, 0);
    chk("outside err", n_derr, 1);
    ext_mode_in = 1'b1;
    int_req(1'b1, 1'b0, 1'b0, 48'h0f00_0000_0200);
    chk("ext wr cmd", last_tx.cmd, 6'h29);
    chk("ext wr port", last_port, link1_upper_port);
    rx(6'h2c, 40'h00_0000_0010, 8'h00);
    chk("ext bad wr", n_bad, 1);
    chk("ext bad svc", n_svc, 0);
    ext_mode_in = 1'b0;
    $display("test internal done");
  endtask : test_internal

  task automatic test_link_rx;
    logic [5:0] nops [3] = '{CMD_NOP, CMD_FLUSH, CMD_BCAST};
    rx(6'h14, 40'h00_0000_0040, 8'h00);
    chk("hit svc", n_svc, 1);
    chk("hit region", last_svc.region, REG_MEM);
    chk("hit uncache", last_svc.uncache, 1'b1);
    rx(6'h14, 40'h10_0000_0040, 8'h00);
    chk("miss fwd", n_tx, 1);
    chk("miss addr", last_tx.addr, 40'h10_0000_0040);
    chk("miss port", last_port, link0_lower_port);
    foreach (nops[i]) begin
      rx(nops[i], 40'h00_0000_0040, 8'h00);
      chk("no effect", n_svc + n_tx + n_done, 0);
    end
    rx(CMD_FENCE, 40'h00_0000_0000, 8'h00);
    chk("fence", n_fence, 1);
    rx(CMD_TGT_DONE, 40'h00_0000_0000, 8'h00);
    chk("tgt done", n_done, 1);
    $display("test link rx done");
  endtask : test_link_rx

  task automatic test_intr;
    rx(6'h2c, INTR_BASE, 8'h05);
    chk("vec 5", intr_vec_out[5], 1'b1);
    chk("notify", intr_notify_out, 1'b1);
    rx(6'h2c, INTR_BASE, 8'hff);
    chk("vec 255", intr_vec_out[255], 1'b1);
    chk("no eoi", n_tx, 0);
    clr[5] = 1'b1;
    @(posedge sys_clk_in);
    #1 clr[5] = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1 chk("masked notify", intr_notify_out, 1'b0);
    rx(6'h2c, SYSMSG_BASE, 8'h00);
    chk("pic busy", pic_busy_out, 1'b1);
    chk("pic query", last_tx.addr, PIC_BASE);
    chk("pic query rd", last_tx.cmd[5:3], 3'b010);
    rx(CMD_RD_RESP, PIC_BASE, 8'h21);
    chk("pic vec", intr_vec_out[33], 1'b1);
    chk("pic held", pic_busy_out, 1'b1);
    pic_clear_in = 1'b1;
    @(posedge sys_clk_in);
    #1 pic_clear_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1 chk("pic free", pic_busy_out, 1'b0);
    $display("test intr done");
  endtask : test_intr

  task automatic test_slave;
    do_reset(1'b0);
    rx(6'h14, 40'h10_0000_0040, 8'h00);
    chk("slave err cmd", last_tx.cmd, CMD_RD_RESP);
    chk("slave err flag", last_tx.err, 1'b1);
    chk("slave no svc", n_svc, 0);
    $display("test slave done");
  endtask : test_slave

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    {rstn_in, ext_mode_in, strap, int_req_valid_in, pic_clear_in} = '0;
    int_req_in = '0;
    clr = '0;
    mask = 256'h0020;
    rx_win[0] = '{en: 1'b1, base: 40'h00_0000_0000, mask: 40'hff_0000_0000};
    rx_win[1] = '{en: 1'b1, base: INTR_BASE, mask: 40'hff_ff00_0000};
    rx_win[2] = '{en: 1'b1, base: PIC_BASE, mask: 40'hff_ffe0_0000};
    post_win = '0;
    post_win[0] = '{en: 1'b1, base: 40'h01_0000_0000, mask: 40'hff_0000_0000};
    pref_win = '0;
    unc_win = '0;
    unc_win[0] = '{en: 1'b1, base: 40'h00_0000_0000, mask: 40'hff_fff0_0000};
    do_reset(1'b1);
    test_internal();
    test_link_rx();
    test_intr();
    test_slave();
    summarize();
  end
endmodule : link_cmd_decode_addr_windows_test
`default_nettype wire
